// ---- luef_pkg.sv ----
package luef_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] EVENT_FLAGS_LINE_OFF = 8'h19;
	localparam logic [7:0] EVENT_FLAGS_PATH_OFF = 8'h1a;
	localparam logic [7:0] ERROR_COUNT_LOW_OFF  = 8'h1b;
	localparam logic [7:0] ERROR_COUNT_HIGH_OFF = 8'h1c;
	localparam logic [7:0] UNMAPPED_READ_VAL    = 8'h00;

	// ----------------------------------------
	// Field layout and widths
	// ----------------------------------------
	localparam int LINE_W = 7;
	localparam int PATH_W = 8;
	localparam int CNT_W  = 16;
	localparam int LINE_SIGNAL_LOST_BIT   = 0;
	localparam int LINE_ALARM_BIT         = 1;
	localparam int LINE_DRIVER_FAULT_BIT  = 2;
	localparam int LINE_TX_CLOCK_BIT      = 3;
	localparam int LINE_PATTERN_SYNC_BIT  = 4;
	localparam int LINE_LOOP_DEACT_BIT    = 5;
	localparam int LINE_LOOP_ACT_BIT      = 6;
	localparam int PATH_CNT_OVF_BIT       = 0;
	localparam int PATH_TIMER_BIT         = 1;
	localparam int PATH_CODE_VIOL_BIT     = 2;
	localparam int PATH_EXCESS_ZERO_BIT   = 3;
	localparam int PATH_BIT_ERROR_BIT     = 4;
	localparam int PATH_JITTER_UDF_BIT    = 5;
	localparam int PATH_JITTER_OVF_BIT    = 6;
	localparam int PATH_WAVE_OVF_BIT      = 7;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0]       RD_DATA_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST     = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX     = 16'hffff;
	localparam logic [6:0]       TX_LOSS_CYC = 7'h46;
	localparam logic [6:0]       TX_CNT_RST  = 7'h00;

	function automatic logic luef_hit(input logic [7:0] addr, input logic [7:0] off);
		luef_hit = (addr == off);
	endfunction

endpackage

// ---- luef_event_latch.sv ----
`timescale 1ns/100ps
module luef_event_latch #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Event sources and control
	input  wire logic [W-1:0] status,
	input  wire logic [W-1:0] mask,
	input  wire logic [W-1:0] edge_sel,
	input  wire logic         clr,
	// Latched flags and unregistered per-bit set events
	output logic [W-1:0]      flags_q,
	output logic [W-1:0]      set_evt
);
	import luef_pkg::*;

	typedef struct packed {
		logic [W-1:0] prev;
		logic [W-1:0] flags;
	} luef_latch_state_t;

	luef_latch_state_t s_q, s_d;

	// ----------------------------------------
	// Per-bit event detection
	// ----------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_bit
		// Any change when edge select is high, else rising only
		assign set_evt[i] = ~mask[i] & (status[i] ^ s_q.prev[i]) & (edge_sel[i] | status[i]);
	end

	always_comb begin
		s_d       = s_q;
		s_d.prev  = status;
		// Set beats clear so no event is lost
		s_d.flags = (clr ? '0 : s_q.flags) | set_evt;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags_q = s_q.flags;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_set_sticks;
		@(posedge clk) disable iff (!rstn)
		(set_evt != '0) |=> ((flags_q & $past(set_evt)) == $past(set_evt));
	endproperty
	a_set_sticks: assert property (p_set_sticks) else $error("event flag not latched");

	property p_masked_quiet;
		@(posedge clk) disable iff (!rstn)
		clr && (mask == '1) |=> (flags_q == '0);
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("masked event set flag");
endmodule

// ---- luef_tx_clock_monitor.sv ----
`timescale 1ns/100ps
module luef_tx_clock_monitor (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Transmit clock pin
	input  wire logic transmit_clock_in,
	// Loss level
	output logic      tx_clock_missing_q
);
	import luef_pkg::*;

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       prev;
		logic [6:0] idle;
		logic       loss;
	} luef_txmon_state_t;

	luef_txmon_state_t s_q, s_d;
	logic              toggled;

	assign toggled = s_q.sync2 ^ s_q.prev;

	// ----------------------------------------
	// Idle counter
	// ----------------------------------------
	always_comb begin
		s_d       = s_q;
		s_d.sync1 = transmit_clock_in;
		s_d.sync2 = s_q.sync1;
		s_d.prev  = s_q.sync2;
		if (toggled) begin
			s_d.idle = TX_CNT_RST;
			s_d.loss = 1'b0;
		end else if (s_q.idle >= TX_LOSS_CYC) begin
			// Idle count at the limit; counter parks to avoid wrap
			s_d.loss = 1'b1;
		end else begin
			s_d.idle = s_q.idle + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tx_clock_missing_q = s_q.loss;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_loss_after_limit;
		@(posedge clk) disable iff (!rstn)
		$rose(tx_clock_missing_q) |-> ($past(s_q.idle) == TX_LOSS_CYC);
	endproperty
	a_loss_after_limit: assert property (p_loss_after_limit) else $error("loss timing wrong");

	property p_toggle_clears;
		@(posedge clk) disable iff (!rstn)
		toggled |=> !tx_clock_missing_q;
	endproperty
	a_toggle_clears: assert property (p_toggle_clears) else $error("loss held after toggle");

	c_loss: cover property (@(posedge clk) disable iff (!rstn) $rose(tx_clock_missing_q));
endmodule

// ---- luef_event_flags.sv ----
`timescale 1ns/100ps
module luef_event_flags (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// Register read port
	input  wire logic                     rd_en,
	input  wire logic [7:0]               rd_addr,
	output logic [7:0]                    rd_data_q,
	output logic                          rd_valid_q,
	// Line status levels and transmit clock pin
	input  wire logic                     loop_activate_code_status,
	input  wire logic                     loop_deactivate_code_status,
	input  wire logic                     pattern_sync_status,
	input  wire logic                     driver_fault_status,
	input  wire logic                     alarm_signal_status,
	input  wire logic                     signal_lost_status,
	input  wire logic                     transmit_clock_in,
	// Path event sources
	input  wire logic                     wave_amplitude_overflow,
	input  wire logic                     jitter_buffer_overflow,
	input  wire logic                     jitter_buffer_underflow,
	input  wire logic                     pattern_bit_error,
	input  wire logic                     excess_zeros,
	input  wire logic                     code_violation,
	input  wire logic                     second_timer_expired,
	input  wire logic                     error_count_inc,
	// Masks and edge selects
	input  wire logic [luef_pkg::LINE_W-1:0] line_event_mask,
	input  wire logic [luef_pkg::LINE_W-1:0] line_edge_select,
	input  wire logic [luef_pkg::PATH_W-1:0] path_event_mask,
	input  wire logic [luef_pkg::PATH_W-1:0] path_edge_select,
	// Interrupt and status
	output logic                          irq_q,
	output logic                          tx_clock_missing_q
);
	import luef_pkg::*;

	typedef struct packed {
		logic [7:0]       rd_data;
		logic             rd_valid;
		logic [CNT_W-1:0] cnt;
		logic             irq;
		logic             tx_missing;
	} luef_top_state_t;

	luef_top_state_t   s_q, s_d;
	logic [LINE_W-1:0] line_status;
	logic [PATH_W-1:0] path_status;
	logic [LINE_W-1:0] event_flags_line;
	logic [PATH_W-1:0] event_flags_path;
	logic [LINE_W-1:0] line_set;
	logic [PATH_W-1:0] path_set;
	logic              line_clr;
	logic              path_clr;
	logic              cnt_ovf;
	logic              tx_loss;

	// ----------------------------------------
	// Event source assembly
	// ----------------------------------------
	always_comb begin
		line_status[LINE_LOOP_ACT_BIT]     = loop_activate_code_status;
		line_status[LINE_LOOP_DEACT_BIT]   = loop_deactivate_code_status;
		line_status[LINE_PATTERN_SYNC_BIT] = pattern_sync_status;
		line_status[LINE_TX_CLOCK_BIT]     = tx_loss;
		line_status[LINE_DRIVER_FAULT_BIT] = driver_fault_status;
		line_status[LINE_ALARM_BIT]        = alarm_signal_status;
		line_status[LINE_SIGNAL_LOST_BIT]  = signal_lost_status;
	end

	assign path_status = {wave_amplitude_overflow,
		jitter_buffer_overflow,
		jitter_buffer_underflow,
		pattern_bit_error,
		excess_zeros,
		code_violation,
		second_timer_expired,
		cnt_ovf};

	// Wrap of the counter is the overflow event
	assign cnt_ovf = error_count_inc & (s_q.cnt == CNT_MAX);

	// Clear-on-read strobes
	assign line_clr = rd_en & luef_hit(rd_addr, EVENT_FLAGS_LINE_OFF);
	assign path_clr = rd_en & luef_hit(rd_addr, EVENT_FLAGS_PATH_OFF);

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	luef_tx_clock_monitor u_txmon (
		.clk                (clk),
		.rstn               (rstn),
		.transmit_clock_in  (transmit_clock_in),
		.tx_clock_missing_q (tx_loss)
	);

	luef_event_latch #(.W(LINE_W)) u_line (
		.clk      (clk),
		.rstn     (rstn),
		.status   (line_status),
		.mask     (line_event_mask),
		.edge_sel (line_edge_select),
		.clr      (line_clr),
		.flags_q  (event_flags_line),
		.set_evt  (line_set)
	);

	luef_event_latch #(.W(PATH_W)) u_path (
		.clk      (clk),
		.rstn     (rstn),
		.status   (path_status),
		.mask     (path_event_mask),
		.edge_sel (path_edge_select),
		.clr      (path_clr),
		.flags_q  (event_flags_path),
		.set_evt  (path_set)
	);

	// ----------------------------------------
	// Counter, readback, request
	// ----------------------------------------
	always_comb begin
		s_d          = s_q;
		s_d.rd_valid = rd_en;
		if (error_count_inc) begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
		if (rd_en) begin
			// Data captured before the clear lands on the same edge
			if (line_clr) begin
				s_d.rd_data = {1'b0, event_flags_line};
			end else if (path_clr) begin
				s_d.rd_data = event_flags_path;
			end else if (luef_hit(rd_addr, ERROR_COUNT_LOW_OFF)) begin
				s_d.rd_data = s_q.cnt[7:0];
			end else if (luef_hit(rd_addr, ERROR_COUNT_HIGH_OFF)) begin
				s_d.rd_data = s_q.cnt[15:8];
			end else begin
				s_d.rd_data = UNMAPPED_READ_VAL;
			end
		end
		// One cycle behind the flags; drops only after every flag is read away
		s_d.irq = (|event_flags_line) | (|event_flags_path);
		s_d.tx_missing = tx_loss;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{rd_data: RD_DATA_RST, rd_valid: 1'b0, cnt: CNT_RST, irq: 1'b0,
				tx_missing: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_q  = s_q.rd_data;
	assign rd_valid_q = s_q.rd_valid;
	assign irq_q      = s_q.irq;
	// One more flop so the status port is registered
	assign tx_clock_missing_q = s_q.tx_missing;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_line_read_clear;
		line_clr && (line_set == '0) |=>
			(event_flags_line == '0) && (rd_data_q[6:0] == $past(event_flags_line));
	endproperty
	a_line_read_clear: assert property (p_line_read_clear) else $error("line read wrong");

	property p_path_read_clear;
		path_clr && (path_set == '0) |=>
			(event_flags_path == '0) && (rd_data_q == $past(event_flags_path));
	endproperty
	a_path_read_clear: assert property (p_path_read_clear) else $error("path read wrong");

	property p_reserved_zero;
		line_clr |=> (rd_data_q[7] == 1'b0) && rd_valid_q;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_cnt_low;
		rd_en && luef_hit(rd_addr, ERROR_COUNT_LOW_OFF) |=> rd_data_q == $past(s_q.cnt[7:0]);
	endproperty
	a_cnt_low: assert property (p_cnt_low) else $error("low byte wrong");

	property p_cnt_high;
		rd_en && luef_hit(rd_addr, ERROR_COUNT_HIGH_OFF) |=> rd_data_q == $past(s_q.cnt[15:8]);
	endproperty
	a_cnt_high: assert property (p_cnt_high) else $error("high byte wrong");

	property p_ovf_flag;
		cnt_ovf && !path_event_mask[PATH_CNT_OVF_BIT] |=>
			event_flags_path[PATH_CNT_OVF_BIT] && (s_q.cnt == CNT_RST);
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged");

	property p_irq_high;
		(event_flags_line != '0) || (event_flags_path != '0) |=> irq_q;
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("request missing");

	property p_irq_fall;
		$fell(irq_q) |-> $past(line_clr || path_clr, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("request dropped without read");

	property p_read_race;
		line_clr && (line_set != '0) |=> (event_flags_line == $past(line_set));
	endproperty
	a_read_race: assert property (p_read_race) else $error("event lost on read");

	// ----------------------------------------
	// Source to bit mapping
	// ----------------------------------------
	property p_act_bit;
		$rose(loop_activate_code_status) && !line_event_mask[LINE_LOOP_ACT_BIT] |=>
			event_flags_line[LINE_LOOP_ACT_BIT];
	endproperty
	a_act_bit: assert property (p_act_bit) else $error("line bit missing");

	property p_deact_bit;
		$rose(loop_deactivate_code_status) && !line_event_mask[LINE_LOOP_DEACT_BIT] |=>
			event_flags_line[LINE_LOOP_DEACT_BIT];
	endproperty
	a_deact_bit: assert property (p_deact_bit) else $error("line bit missing");

	property p_sync_bit;
		$rose(pattern_sync_status) && !line_event_mask[LINE_PATTERN_SYNC_BIT] |=>
			event_flags_line[LINE_PATTERN_SYNC_BIT];
	endproperty
	a_sync_bit: assert property (p_sync_bit) else $error("line bit missing");

	property p_tx_bit;
		$rose(tx_loss) && !line_event_mask[LINE_TX_CLOCK_BIT] |=>
			event_flags_line[LINE_TX_CLOCK_BIT];
	endproperty
	a_tx_bit: assert property (p_tx_bit) else $error("line bit missing");

	property p_fault_bit;
		$rose(driver_fault_status) && !line_event_mask[LINE_DRIVER_FAULT_BIT] |=>
			event_flags_line[LINE_DRIVER_FAULT_BIT];
	endproperty
	a_fault_bit: assert property (p_fault_bit) else $error("line bit missing");

	property p_alarm_bit;
		$rose(alarm_signal_status) && !line_event_mask[LINE_ALARM_BIT] |=>
			event_flags_line[LINE_ALARM_BIT];
	endproperty
	a_alarm_bit: assert property (p_alarm_bit) else $error("line bit missing");

	property p_lost_bit;
		$rose(signal_lost_status) && !line_event_mask[LINE_SIGNAL_LOST_BIT] |=>
			event_flags_line[LINE_SIGNAL_LOST_BIT];
	endproperty
	a_lost_bit: assert property (p_lost_bit) else $error("line bit missing");

	property p_wave_bit;
		$rose(wave_amplitude_overflow) && !path_event_mask[PATH_WAVE_OVF_BIT] |=>
			event_flags_path[PATH_WAVE_OVF_BIT];
	endproperty
	a_wave_bit: assert property (p_wave_bit) else $error("path bit missing");

	property p_jovf_bit;
		$rose(jitter_buffer_overflow) && !path_event_mask[PATH_JITTER_OVF_BIT] |=>
			event_flags_path[PATH_JITTER_OVF_BIT];
	endproperty
	a_jovf_bit: assert property (p_jovf_bit) else $error("path bit missing");

	property p_judf_bit;
		$rose(jitter_buffer_underflow) && !path_event_mask[PATH_JITTER_UDF_BIT] |=>
			event_flags_path[PATH_JITTER_UDF_BIT];
	endproperty
	a_judf_bit: assert property (p_judf_bit) else $error("path bit missing");

	property p_perr_bit;
		$rose(pattern_bit_error) && !path_event_mask[PATH_BIT_ERROR_BIT] |=>
			event_flags_path[PATH_BIT_ERROR_BIT];
	endproperty
	a_perr_bit: assert property (p_perr_bit) else $error("path bit missing");

	property p_zeros_bit;
		$rose(excess_zeros) && !path_event_mask[PATH_EXCESS_ZERO_BIT] |=>
			event_flags_path[PATH_EXCESS_ZERO_BIT];
	endproperty
	a_zeros_bit: assert property (p_zeros_bit) else $error("path bit missing");

	property p_viol_bit;
		$rose(code_violation) && !path_event_mask[PATH_CODE_VIOL_BIT] |=>
			event_flags_path[PATH_CODE_VIOL_BIT];
	endproperty
	a_viol_bit: assert property (p_viol_bit) else $error("path bit missing");

	property p_timer_bit;
		$rose(second_timer_expired) && !path_event_mask[PATH_TIMER_BIT] |=>
			event_flags_path[PATH_TIMER_BIT];
	endproperty
	a_timer_bit: assert property (p_timer_bit) else $error("path bit missing");

	// ----------------------------------------
	// Edge select and answer timing
	// ----------------------------------------
	property p_rise_only;
		$fell(signal_lost_status) && !line_edge_select[LINE_SIGNAL_LOST_BIT] |->
			!line_set[LINE_SIGNAL_LOST_BIT];
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("falling edge set flag");

	property p_path_rise_only;
		$fell(excess_zeros) && !path_edge_select[PATH_EXCESS_ZERO_BIT] |->
			!path_set[PATH_EXCESS_ZERO_BIT];
	endproperty
	a_path_rise_only: assert property (p_path_rise_only) else $error("falling edge set flag");

	// Reset clears the edge history, so a fall just after reset is no edge
	property p_any_change;
		$fell(signal_lost_status) && line_edge_select[LINE_SIGNAL_LOST_BIT] && $past(rstn) &&
			!line_event_mask[LINE_SIGNAL_LOST_BIT] |=> event_flags_line[LINE_SIGNAL_LOST_BIT];
	endproperty
	a_any_change: assert property (p_any_change) else $error("change not flagged");

	property p_path_any_change;
		$fell(excess_zeros) && path_edge_select[PATH_EXCESS_ZERO_BIT] && $past(rstn) &&
			!path_event_mask[PATH_EXCESS_ZERO_BIT] |=> event_flags_path[PATH_EXCESS_ZERO_BIT];
	endproperty
	a_path_any_change: assert property (p_path_any_change) else $error("change not flagged");

	property p_valid_follows;
		$past(rstn) |-> (rd_valid_q == $past(rd_en));
	endproperty
	a_valid_follows: assert property (p_valid_follows) else $error("answer timing wrong");

	property p_unmapped_zero;
		rd_en && !line_clr && !path_clr && !luef_hit(rd_addr, ERROR_COUNT_LOW_OFF) &&
			!luef_hit(rd_addr, ERROR_COUNT_HIGH_OFF) |=> (rd_data_q == UNMAPPED_READ_VAL);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	c_line_read: cover property (line_clr && (event_flags_line != '0));
	c_path_read: cover property (path_clr && (event_flags_path != '0));
	c_overflow:  cover property (cnt_ovf);
	c_race:      cover property (line_clr && (line_set != '0));
endmodule

// ---- luef_host_model.sv ----
`timescale 1ns/100ps
module luef_host_model (
	// Clock
	input  wire logic       clk,
	// Register read port
	output logic            rd_en,
	output logic [7:0]      rd_addr,
	input  wire logic [7:0] rd_data_q,
	input  wire logic       rd_valid_q
);
	initial begin
		rd_en   = 1'b0;
		rd_addr = 8'h00;
	end

	// ----------------------------------------
	// One read cycle
	// ----------------------------------------
	task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
		@(posedge clk);
		rd_en   <= 1'b1;
		rd_addr <= addr;
		@(posedge clk);
		rd_en   <= 1'b0;
		// Idle address shows the inverse so a stale decode cannot pass
		rd_addr <= ~addr;
		#1;
		ok   = (rd_valid_q === 1'b1);
		data = rd_data_q;
	endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
	import luef_pkg::*;

	logic        clk, rstn, rd_en, rd_valid_q, irq_q, tx_clock_missing_q;
	logic        pin_clk, pin_clk_run, cnt_inc;
	logic [7:0]  rd_addr, rd_data_q, path_st, path_mask, path_esel, el, ep, np;
	logic [6:0]  line_st, line_mask, line_esel, nl;
	logic [15:0] cnt;
	int          failures, n_compared, cycles, n;
	integer      seed;

	luef_event_flags u_luef_event_flags (
		.clk(clk), .rstn(rstn), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.loop_activate_code_status(line_st[6]), .loop_deactivate_code_status(line_st[5]),
		.pattern_sync_status(line_st[4]), .driver_fault_status(line_st[2]),
		.alarm_signal_status(line_st[1]), .signal_lost_status(line_st[0]),
		.transmit_clock_in(pin_clk), .wave_amplitude_overflow(path_st[7]),
		.jitter_buffer_overflow(path_st[6]), .jitter_buffer_underflow(path_st[5]),
		.pattern_bit_error(path_st[4]), .excess_zeros(path_st[3]),
		.code_violation(path_st[2]), .second_timer_expired(path_st[1]),
		.error_count_inc(cnt_inc), .line_event_mask(line_mask),
		.line_edge_select(line_esel), .path_event_mask(path_mask),
		.path_edge_select(path_esel), .irq_q(irq_q),
		.tx_clock_missing_q(tx_clock_missing_q)
	);

	luef_host_model u_luef_host_model (
		.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q)
	);

	// ----------------------------------------
	// Clock, pin clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Pin clock must run from time zero, else loss fires about 71 cycles after reset
	always @(posedge clk) begin
		if (pin_clk_run) begin
			pin_clk <= ~pin_clk;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			$display("CHECK FAILED t=%0t run did not finish", $time);
			final_report();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	function automatic logic [7:0] sets(input logic [7:0] o, v, m, e);
		return ~m & (o ^ v) & (e | v);
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
		logic [7:0] d;
		logic       ok;
		u_luef_host_model.rd(a, d, ok);
		chk({7'h00, ok}, 8'h01, "read answer");
		chk(d, exp, msg);
	endtask

	task automatic chk_irq(input logic exp);
		@(posedge clk);
		#1;
		chk({7'h00, irq_q}, {7'h00, exp}, "irq level");
	endtask

	task automatic pulse_inc(input int k);
		@(posedge clk);
		cnt_inc <= 1'b1;
		repeat (k) @(posedge clk);
		cnt_inc <= 1'b0;
	endtask

	task automatic final_report;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'hf689_0c84;
		rstn = 1'b0;
		line_st = 7'h00;
		path_st = 8'h00;
		line_mask = 7'h7f;
		path_mask = 8'hff;
		line_esel = 7'h00;
		path_esel = 8'h00;
		pin_clk = 1'b0;
		pin_clk_run = 1'b1;
		cnt_inc = 1'b0;
		cnt = 16'h0000;
		failures = 0;
		n_compared = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdc(EVENT_FLAGS_LINE_OFF, 8'h00, "line reset");
		rdc(EVENT_FLAGS_PATH_OFF, 8'h00, "path reset");
		rdc(ERROR_COUNT_LOW_OFF, 8'h00, "low reset");
		rdc(ERROR_COUNT_HIGH_OFF, 8'h00, "high reset");
		$display("test reset done");

		// Early rounds open every mask but the TX clock and overflow bits; later ones draw masks too
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			line_mask <= (i < 15) ? 7'h08 : (7'($random(seed)) | 7'h08);
			path_mask <= (i < 15) ? 8'h01 : (8'($random(seed)) | 8'h01);
			line_esel <= 7'($random(seed));
			path_esel <= 8'($random(seed));
			@(posedge clk);
			nl = 7'($random(seed)) & 7'h77;
			np = 8'($random(seed)) & 8'hfe;
			el = sets({1'b0, line_st}, {1'b0, nl}, {1'b0, line_mask}, {1'b0, line_esel});
			ep = sets(path_st, np, path_mask, path_esel);
			line_st <= nl;
			path_st <= np;
			repeat (2) @(posedge clk);
			chk_irq(|{el, ep});
			rdc(EVENT_FLAGS_LINE_OFF, el, "line flags");
			chk_irq(|ep);
			rdc(EVENT_FLAGS_PATH_OFF, ep, "path flags");
			chk_irq(1'b0);
		end
		$display("test random events done");

		@(posedge clk);
		line_mask <= 7'h7f;
		line_st <= 7'h00;
		@(posedge clk);
		line_mask <= 7'h08;
		line_esel <= 7'h00;
		fork
			rdc(EVENT_FLAGS_LINE_OFF, 8'h00, "read during event");
			begin
				@(posedge clk);
				line_st[0] <= 1'b1;
			end
		join
		rdc(8'h1d, 8'h00, "unmapped");
		rdc(8'h18, 8'h00, "unmapped");
		rdc(EVENT_FLAGS_LINE_OFF, 8'h01, "event kept");
		$display("test read collision done");

		@(posedge clk);
		path_mask <= 8'hfe;
		path_esel <= 8'h00;
		n = 300 + ($unsigned($random(seed)) % 700);
		pulse_inc(n);
		cnt = 16'(n);
		rdc(ERROR_COUNT_LOW_OFF, cnt[7:0], "count low");
		rdc(ERROR_COUNT_HIGH_OFF, cnt[15:8], "count high");
		pulse_inc(65536 - n);
		rdc(ERROR_COUNT_LOW_OFF, 8'h00, "wrap low");
		rdc(ERROR_COUNT_HIGH_OFF, 8'h00, "wrap high");
		rdc(EVENT_FLAGS_PATH_OFF, 8'h01, "overflow flag");
		$display("test counter done");

		@(posedge clk);
		line_mask <= 7'h77;
		pin_clk_run <= 1'b0;
		repeat (60) @(posedge clk);
		#1;
		chk({7'h00, tx_clock_missing_q}, 8'h00, "loss too early");
		repeat (30) @(posedge clk);
		#1;
		chk({7'h00, tx_clock_missing_q}, 8'h01, "loss missing");
		rdc(EVENT_FLAGS_LINE_OFF, 8'h08, "loss flag");
		@(posedge clk);
		pin_clk_run <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		chk({7'h00, tx_clock_missing_q}, 8'h00, "loss stuck");
		rdc(EVENT_FLAGS_LINE_OFF, 8'h00, "falling loss");
		$display("test clock loss done");
		final_report();
	end
endmodule
